// [sfc_front_end.sv]
// Serial flash command framer, status register and status read-out.
`timescale 1ns/10ps
// Function
// - Protect mode 1,0 refuses all status writes until the next power cycle.
// - Power cycle turns protect mode 1,0 back into 0,0.
// - Protect mode 1,1 refuses every status write forever.
// - Quad enable defaults 0; at 1 protect and hold pins become IO2, IO3.
// - Three lock bits S13-S11 default 0, settable once, never cleared.
// - Complement bit S14 defaults 0 and alters block protect mapping.
// - Suspend 75H sets erase flag S15 or program flag S10.
// - Resume 7AH or power cycle clears both suspend flags.
// - High performance flag reads 1 in that mode, default 0.
// - Two-bit drive strength field, default 01.
// - Bits arrive MSB first, latched on rising serial clock.
// - Frame opens with one opcode byte, then address, data or nothing.
// - Read commands drive data out after the input phase.
// - Chip select rising ends any read; device returns to deselected.
// - Write-type commands run only when bit count is a multiple of eight.
// - Partial program byte at deselect does nothing, write latch stays.
// - 05H, 35H, 15H read status bytes repeatedly; 01H, 31H, 11H write them.
module sfc_front_end #(
  parameter int CNT_W = 12,
  // Arbitrary identity value returned by the wake command.
  parameter logic [7:0] WAKE_ID = 8'h5a
) (
  // System clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // Serial link
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic wp_n_in,
  output logic so_out,
  output logic so_oe_out,
  // Non-volatile image
  input wire sfc_pkg::sfc_nv_t nv_image_in,
  output sfc_pkg::sfc_nv_t nv_image_out,
  // Array side
  input wire logic busy_in,
  input wire logic erase_busy_in,
  input wire logic program_busy_in,
  output logic req_valid_out,
  output sfc_pkg::sfc_req_t req_out,
  // Pad control
  output logic quad_io_en_out,
  output logic [1:0] drive_strength_out,
  output logic high_perf_out
);
  import sfc_pkg::*;

  // The counter must at least reach the 40-bit program frame.
  if (CNT_W < 6) begin : g_cnt_chk
    $error("CNT_W too small for frame counts");
  end

  // ------------------------------------------------------------------
  // Serial clock domain
  // ------------------------------------------------------------------
  // Only the frame flag is cleared by deselect; the captured frame must
  // survive deselect so the system side can read it while clocks stand.
  logic link_rst_n;
  logic act_r, act_nxt, long_r, long_nxt, tgl_r, tgl_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [7:0] shf_r, shf_nxt, opc_r, opc_nxt, dat_r, dat_nxt, in_byte;
  logic [23:0] addr_r, addr_nxt;
  assign link_rst_n = arst_n_in & ~cs_n_in;
  assign in_byte = {shf_r[6:0], si_in};

  always_comb begin
    act_nxt = 1'b1;
    cnt_nxt = act_r ? cnt_r + 1'b1 : CNT_W'(1);
    long_nxt = act_r & (long_r | (&cnt_r));
    tgl_nxt = act_r ? tgl_r : ~tgl_r;
    shf_nxt = in_byte;
    opc_nxt = opc_r;
    addr_nxt = addr_r;
    dat_nxt = dat_r;
    if (!long_r && cnt_nxt == CNT_W'(OPC_BITS)) begin
      opc_nxt = in_byte;
    end
    if (!long_r && cnt_nxt[2:0] == 3'h0 && cnt_nxt > CNT_W'(OPC_BITS) &&
        cnt_nxt <= CNT_W'(ADDR_END_BITS)) begin
      addr_nxt = {addr_r[15:0], in_byte};
    end
    if (!long_r && cnt_nxt == CNT_W'(SRW_BITS)) begin
      dat_nxt = in_byte;
    end
  end

  always_ff @(posedge sclk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      act_r <= 1'b0;
    end else begin
      act_r <= act_nxt;
    end
  end

  always_ff @(posedge sclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_r <= '0;
      long_r <= 1'b0;
      tgl_r <= 1'b0;
      shf_r <= 8'h00;
      opc_r <= 8'h00;
      addr_r <= 24'h000000;
      dat_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
      long_r <= long_nxt;
      tgl_r <= tgl_nxt;
      shf_r <= shf_nxt;
      opc_r <= opc_nxt;
      addr_r <= addr_nxt;
      dat_r <= dat_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Data out on the falling serial clock
  // ------------------------------------------------------------------
  // Status bytes change only between frames, except the busy bit of sr1 that follows busy_in,
  // so the other bits are steady while this domain reads them.
  logic [7:0] sr1, sr2, sr3, rd_byte;
  logic so_r, so_nxt, oe_r, oe_nxt, rd_en;
  always_comb begin
    rd_byte = sr1;
    rd_en = act_r && (cnt_r >= CNT_W'(OPC_BITS) || long_r);
    unique case (opc_r)
      OP_RD_SR1: rd_byte = sr1;
      OP_RD_SR2: rd_byte = sr2;
      OP_RD_SR3: rd_byte = sr3;
      OP_WAKE_ID: begin
        rd_byte = WAKE_ID;
        rd_en = act_r && (cnt_r >= CNT_W'(WAKE_OUT_BITS) || long_r);
      end
      default: rd_en = 1'b0;
    endcase
    oe_nxt = rd_en;
    so_nxt = rd_en ? rd_byte[3'h7 - cnt_r[2:0]] : 1'b0;
  end

  always_ff @(negedge sclk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      so_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      so_r <= so_nxt;
      oe_r <= oe_nxt;
    end
  end
  assign so_out = so_r;
  assign so_oe_out = oe_r;

  // ------------------------------------------------------------------
  // Crossing into the system clock domain
  // ------------------------------------------------------------------
  logic cs_s1_r, cs_s2_r, cs_d_r, tg_s1_r, tg_s2_r, wp_s1_r, wp_s2_r;
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_d_r <= 1'b1;
      tg_s1_r <= 1'b0;
      tg_s2_r <= 1'b0;
      wp_s1_r <= 1'b0;
      wp_s2_r <= 1'b0;
    end else begin
      cs_s1_r <= cs_n_in;
      cs_s2_r <= cs_s1_r;
      cs_d_r <= cs_s2_r;
      tg_s1_r <= tgl_r;
      tg_s2_r <= tg_s1_r;
      wp_s1_r <= wp_n_in;
      wp_s2_r <= wp_s1_r;
    end
  end

  // ------------------------------------------------------------------
  // Command execution and status register
  // ------------------------------------------------------------------
  sfc_nv_t nv_r, nv_nxt;
  sfc_req_t req_r, req_nxt;
  logic ld_r, ld_nxt, seen_r, seen_nxt, wel_r, wel_nxt, rv_r, rv_nxt;
  logic sus_e_r, sus_e_nxt, sus_p_r, sus_p_nxt, hpm_r, hpm_nxt;
  logic exec, bnd, sr_open, wr_ok, ge16, ge32, ge40;

  // Deselect seen by the system side closes a frame; the toggle tells a
  // real frame apart from a chip select pulse with no clocks in it.
  assign exec = ld_r & cs_s2_r & ~cs_d_r & (tg_s2_r != seen_r);
  assign bnd = cnt_r[2:0] == 3'h0;
  assign ge16 = long_r || cnt_r >= CNT_W'(SRW_BITS);
  assign ge32 = long_r || cnt_r >= CNT_W'(ADDR_END_BITS);
  assign ge40 = long_r || cnt_r >= CNT_W'(PGM_BITS);
  assign wr_ok = wel_r & ~busy_in;
  assign sr_open = nv_r.protect_mode == PM_SOFT ||
                   (nv_r.protect_mode == PM_HW && wp_s2_r);

  always_comb begin
    nv_nxt = nv_r;
    ld_nxt = 1'b1;
    seen_nxt = exec ? tg_s2_r : seen_r;
    wel_nxt = wel_r;
    sus_e_nxt = sus_e_r;
    sus_p_nxt = sus_p_r;
    hpm_nxt = hpm_r;
    rv_nxt = 1'b0;
    req_nxt = req_r;
    if (!ld_r) begin
      nv_nxt = nv_image_in;
      if (nv_image_in.protect_mode == PM_LOCK) begin
        nv_nxt.protect_mode = PM_SOFT;
      end
    end else if (exec) begin
      unique case (opc_r)
        OP_WR_EN: if (bnd) wel_nxt = 1'b1;
        OP_WR_DIS: if (bnd) wel_nxt = 1'b0;
        OP_WR_SR1, OP_WR_SR2, OP_WR_SR3: begin
          if (bnd && ge16 && wr_ok && sr_open) begin
            wel_nxt = 1'b0;
            if (opc_r == OP_WR_SR1) begin
              nv_nxt.protect_mode[0] = dat_r[7];
              nv_nxt.block_protect_field = dat_r[6:2];
            end else if (opc_r == OP_WR_SR2) begin
              nv_nxt.protect_mode[1] = dat_r[0];
              nv_nxt.quad_enable_bit = dat_r[1];
              nv_nxt.security_lock_bits = nv_r.security_lock_bits | dat_r[5:3];
              nv_nxt.protect_complement = dat_r[6];
            end else begin
              nv_nxt.drive_strength_field = dat_r[6:5];
            end
          end
        end
        OP_PGM, OP_QPGM, OP_FPGM: begin
          if (bnd && ge40 && wr_ok) begin
            rv_nxt = 1'b1;
            wel_nxt = 1'b0;
          end
        end
        OP_SEC_ER, OP_B32_ER, OP_B64_ER: begin
          if (!long_r && cnt_r == CNT_W'(ADDR_END_BITS) && wr_ok) begin
            rv_nxt = 1'b1;
            wel_nxt = 1'b0;
          end
        end
        OP_CHIP_ER0, OP_CHIP_ER1: begin
          if (!long_r && cnt_r == CNT_W'(OPC_BITS) && wr_ok) begin
            rv_nxt = 1'b1;
            wel_nxt = 1'b0;
          end
        end
        OP_PWR_DN: rv_nxt = bnd && !long_r && cnt_r == CNT_W'(OPC_BITS);
        OP_SUSPEND: begin
          if (erase_busy_in) sus_e_nxt = 1'b1;
          else if (program_busy_in) sus_p_nxt = 1'b1;
        end
        OP_RESUME: begin
          sus_e_nxt = 1'b0;
          sus_p_nxt = 1'b0;
        end
        OP_HIPERF: if (bnd && ge32) hpm_nxt = 1'b1;
        default: ;
      endcase
      if (rv_nxt) req_nxt = '{opcode: opc_r, addr: addr_r};
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      nv_r <= NV_RST;
      ld_r <= 1'b0;
      seen_r <= 1'b0;
      wel_r <= 1'b0;
      sus_e_r <= 1'b0;
      sus_p_r <= 1'b0;
      hpm_r <= 1'b0;
      rv_r <= 1'b0;
      req_r <= '0;
    end else begin
      nv_r <= nv_nxt;
      ld_r <= ld_nxt;
      seen_r <= seen_nxt;
      wel_r <= wel_nxt;
      sus_e_r <= sus_e_nxt;
      sus_p_r <= sus_p_nxt;
      hpm_r <= hpm_nxt;
      rv_r <= rv_nxt;
      req_r <= req_nxt;
    end
  end

  assign sr1 = {nv_r.protect_mode[0], nv_r.block_protect_field, wel_r, busy_in};
  assign sr2 = {sus_e_r, nv_r.protect_complement, nv_r.security_lock_bits, sus_p_r,
                nv_r.quad_enable_bit, nv_r.protect_mode[1]};
  assign sr3 = {1'b0, nv_r.drive_strength_field, hpm_r, 4'h0};
  assign nv_image_out = nv_r;
  assign quad_io_en_out = nv_r.quad_enable_bit;
  assign drive_strength_out = nv_r.drive_strength_field;
  assign high_perf_out = hpm_r;
  assign req_valid_out = rv_r;
  assign req_out = req_r;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic is_srw;
  assign is_srw = opc_r == OP_WR_SR1 || opc_r == OP_WR_SR2 || opc_r == OP_WR_SR3;

  a_lock_refuse: assert property (exec && is_srw && nv_r.protect_mode == PM_LOCK
    |=> $stable(nv_r) [*3]) else $error("status changed in lock mode");
  a_load_unlock: assert property (!ld_r |=> nv_r.protect_mode != PM_LOCK)
    else $error("lock mode survived power cycle");
  a_otp_refuse: assert property (nv_r.protect_mode == PM_OTP |=> nv_r.protect_mode == PM_OTP
    && $stable(nv_r.block_protect_field)) else $error("otp status changed");
  a_lock_sticky: assert property (ld_r && $past(ld_r) |-> (nv_r.security_lock_bits
    & $past(nv_r.security_lock_bits)) == $past(nv_r.security_lock_bits))
    else $error("lock bit cleared");
  a_susp_set: assert property (exec && opc_r == OP_SUSPEND && erase_busy_in
    |=> sus_e_r && sr2[7]) else $error("erase suspend flag not set");
  a_resume_clr: assert property (exec && opc_r == OP_RESUME |=> !sr2[7] && !sr2[2])
    else $error("suspend flags not cleared");
  a_boundary_chk: assert property (exec && !bnd |=> !req_valid_out && $stable(wel_r))
    else $error("partial byte command executed");
  a_erase_req: assert property (exec && opc_r == OP_SEC_ER && cnt_r == CNT_W'(ADDR_END_BITS)
    && wr_ok |=> req_valid_out && req_out.addr == $past(addr_r) ##1 !req_valid_out)
    else $error("erase request wrong");
  a_write_enable_cmd_set: assert property (exec && opc_r == OP_WR_EN && bnd |=> wel_r && sr1[1])
    else $error("write enable not latched");

  c_status_write: cover property (exec && is_srw && wr_ok && sr_open);
  c_erase_go: cover property (req_valid_out && req_out.opcode == OP_B64_ER);
  c_partial_pgm: cover property (exec && opc_r == OP_PGM && !bnd && wel_r);
  c_suspend: cover property (exec && opc_r == OP_SUSPEND ##[1:400] exec && opc_r == OP_RESUME);
endmodule

// [sfc_front_end_tb_top.sv]
// Self-checking testbench of the serial flash command front end.
`timescale 1ns/10ps
module sfc_front_end_tb_top;
  import sfc_pkg::*;
  logic ref_clk_in;
  logic arst_n_in;
  logic sclk;
  logic cs_n;
  logic si;
  logic so_out;
  logic so_oe_out;
  logic wp_n_in;
  logic busy_in;
  logic erase_busy_in;
  logic program_busy_in;
  logic req_valid_out;
  logic quad_io_en_out;
  logic high_perf_out;
  logic [1:0] drive_strength_out;
  sfc_nv_t nv_image_in;
  sfc_nv_t nv_image_out;
  sfc_req_t req_out;
  sfc_req_t req_last;
  logic [31:0] r;
  int bad_count = 0;
  int comparisons = 0;
  int req_cnt = 0;
  int cyc = 0;
  sfc_front_end u_dut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .si_in(si), .wp_n_in(wp_n_in), .so_out(so_out), .so_oe_out(so_oe_out),
    .nv_image_in(nv_image_in), .nv_image_out(nv_image_out), .busy_in(busy_in),
    .erase_busy_in(erase_busy_in), .program_busy_in(program_busy_in),
    .req_valid_out(req_valid_out), .req_out(req_out), .quad_io_en_out(quad_io_en_out),
    .drive_strength_out(drive_strength_out), .high_perf_out(high_perf_out));
  sfc_host_model u_host (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si), .so_in(so_out));
  always #12.5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    if (req_valid_out === 1'b1) begin
      req_cnt <= req_cnt + 1;
      req_last <= req_out;
    end
  end
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic end_sim();
    $display("counts: %0d compared, %0d bad", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic pc(input sfc_nv_t n);
    @(posedge ref_clk_in);
    nv_image_in <= n;
    arst_n_in <= 1'b0;
    repeat (16) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
  endtask
  task automatic cmd(input logic [7:0] op, input int nb);
    u_host.frame({op, 56'h0}, nb, 0, r);
  endtask
  task automatic wen();
    cmd(OP_WR_EN, 8);
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    u_host.frame({op, d, 48'h0}, 16, 0, r);
  endtask
  task automatic rd(input logic [7:0] op, input int nr);
    u_host.frame({op, 56'h0}, 8, nr, r);
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_status();
    rd(OP_RD_SR1, 16);
    chk(r, 32'h0);
    rd(OP_RD_SR3, 12);
    chk(r, 32'h202);
    chk(so_oe_out, 1'b0);
    chk(nv_image_out, NV_RST);
    chk(drive_strength_out, 2'h1);
    chk({quad_io_en_out, high_perf_out}, 2'h0);
    cmd(OP_WR_EN, 9);
    rd(OP_RD_SR1, 8);
    chk(r, 32'h0);
    wen();
    rd(OP_RD_SR1, 8);
    chk(r, 32'h2);
    wr(OP_WR_SR2, 8'h4a);
    rd(OP_RD_SR2, 8);
    chk(r, 32'h4a);
    chk(quad_io_en_out, 1'b1);
    wen();
    wr(OP_WR_SR2, 8'h00);
    rd(OP_RD_SR2, 8);
    chk(r, 32'h08);
    for (int d = 0; d < 4; d++) begin
      wen();
      wr(OP_WR_SR3, 8'(d << 5));
      chk(drive_strength_out, 32'(d));
    end
    $display("status test done");
  endtask
  task automatic t_protect();
    sfc_nv_t n;
    wen();
    wr(OP_WR_SR2, 8'h01);
    chk(nv_image_out.protect_mode, PM_LOCK);
    wen();
    wr(OP_WR_SR1, 8'h04);
    rd(OP_RD_SR1, 8);
    chk(r, 32'h02);
    pc(nv_image_out);
    chk(nv_image_out.protect_mode, PM_SOFT);
    wen();
    wr(OP_WR_SR1, 8'h04);
    rd(OP_RD_SR1, 8);
    chk(r, 32'h04);
    n = NV_RST;
    n.protect_mode = PM_OTP;
    pc(n);
    wen();
    wr(OP_WR_SR1, 8'h08);
    rd(OP_RD_SR1, 8);
    chk(r, 32'h82);
    n = NV_RST;
    n.protect_mode = PM_HW;
    pc(n);
    @(posedge ref_clk_in);
    wp_n_in <= 1'b0;
    wen();
    wr(OP_WR_SR1, 8'h88);
    rd(OP_RD_SR1, 8);
    chk(r, 32'h82);
    @(posedge ref_clk_in);
    wp_n_in <= 1'b1;
    wr(OP_WR_SR1, 8'h88);
    rd(OP_RD_SR1, 8);
    chk(r, 32'h88);
    $display("protect test done");
  endtask
  task automatic t_suspend();
    pc(NV_RST);
    @(posedge ref_clk_in);
    erase_busy_in <= 1'b1;
    program_busy_in <= 1'b1;
    cmd(OP_SUSPEND, 8);
    rd(OP_RD_SR2, 8);
    chk(r, 32'h80);
    cmd(OP_RESUME, 8);
    rd(OP_RD_SR2, 8);
    chk(r, 32'h0);
    @(posedge ref_clk_in);
    erase_busy_in <= 1'b0;
    cmd(OP_SUSPEND, 8);
    rd(OP_RD_SR2, 8);
    chk(r, 32'h04);
    @(posedge ref_clk_in);
    program_busy_in <= 1'b0;
    pc(NV_RST);
    rd(OP_RD_SR2, 8);
    chk(r, 32'h0);
    $display("suspend test done");
  endtask
  task automatic t_array();
    logic [7:0] ops[3] = '{OP_SEC_ER, OP_B32_ER, OP_B64_ER};
    int n0;
    for (int k = 0; k < 3; k++) begin
      wen();
      n0 = req_cnt;
      u_host.frame({ops[k], 24'hc3a50f + 24'(k), 32'h0}, 32, 0, r);
      chk(req_cnt - n0, 1);
      chk(req_last, {ops[k], 24'hc3a50f + 24'(k)});
    end
    wen();
    n0 = req_cnt;
    u_host.frame({OP_SEC_ER, 56'h0}, 33, 0, r);
    u_host.frame({OP_PGM, 24'h0a0b0c, 8'h55, 24'h0}, 44, 0, r);
    chk(req_cnt - n0, 0);
    rd(OP_RD_SR1, 8);
    chk(r, 32'h02);
    u_host.frame({OP_PGM, 24'h0a0b0c, 8'h55, 24'h0}, 40, 0, r);
    chk(req_last, {OP_PGM, 24'h0a0b0c});
    @(posedge ref_clk_in);
    busy_in <= 1'b1;
    rd(OP_RD_SR1, 8);
    chk(r, 32'h01);
    @(posedge ref_clk_in);
    busy_in <= 1'b0;
    u_host.frame({OP_WAKE_ID, 56'h0}, 32, 16, r);
    chk(r, 32'h5a5a);
    u_host.frame({OP_HIPERF, 56'h0}, 32, 0, r);
    rd(OP_RD_SR3, 8);
    chk({r[7:0], high_perf_out}, 9'h061);
    wen();
    cmd(OP_WR_DIS, 8);
    rd(OP_RD_SR1, 8);
    chk(r, 32'h0);
    wen();
    n0 = req_cnt;
    cmd(OP_CHIP_ER1, 8);
    chk(req_last.opcode, OP_CHIP_ER1);
    cmd(OP_PWR_DN, 8);
    chk(req_last.opcode, OP_PWR_DN);
    chk(req_cnt - n0, 2);
    $display("array test done");
  endtask
  initial begin
    ref_clk_in = 1'b0;
    arst_n_in = 1'b0;
    wp_n_in = 1'b1;
    busy_in = 1'b0;
    erase_busy_in = 1'b0;
    program_busy_in = 1'b0;
    nv_image_in = NV_RST;
    pc(NV_RST);
    t_status();
    t_protect();
    t_suspend();
    t_array();
    end_sim();
  end
endmodule

// [sfc_host_model.sv]
// SPI host model that frames commands for the serial flash front end.
`timescale 1ns/10ps
module sfc_host_model (
  // Serial link
  output logic sclk_out,
  output logic cs_n_out,
  output logic si_out,
  input wire logic so_in
);
  // ------------------------------------------------------------------
  // Framing
  // ------------------------------------------------------------------
  // The clock stands still between frames, as a real host leaves it.
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end
  // Sends nb bits of tx from the top down, then clocks nr bits back in.
  task automatic frame(input logic [63:0] tx, input int nb, input int nr,
                       output logic [31:0] rx);
    int i;
    rx = '0;
    #7 cs_n_out = 1'b0;
    for (i = 0; i < nb + nr; i++) begin
      si_out = (i < nb) ? tx[63-i] : ~si_out;
      #16 sclk_out = 1'b1;
      if (i >= nb) rx = {rx[30:0], so_in};
      #16 sclk_out = 1'b0;
    end
    #16 cs_n_out = 1'b1;
    si_out = ~si_out;
    // The gap covers the deselect sync and the command's execution.
    #300;
  endtask
endmodule

// [sfc_pkg.sv]
// Constants and types shared by the serial flash command and status front end.
package sfc_pkg;
  // ------------------------------------------------------------------
  // Command opcodes
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_RD_SR1 = 8'h05;
  localparam logic [7:0] OP_RD_SR2 = 8'h35;
  localparam logic [7:0] OP_RD_SR3 = 8'h15;
  localparam logic [7:0] OP_WR_SR1 = 8'h01;
  localparam logic [7:0] OP_WR_SR2 = 8'h31;
  localparam logic [7:0] OP_WR_SR3 = 8'h11;
  localparam logic [7:0] OP_PGM = 8'h02;
  localparam logic [7:0] OP_QPGM = 8'h32;
  localparam logic [7:0] OP_FPGM = 8'hf2;
  localparam logic [7:0] OP_SEC_ER = 8'h20;
  localparam logic [7:0] OP_B32_ER = 8'h52;
  localparam logic [7:0] OP_B64_ER = 8'hd8;
  localparam logic [7:0] OP_CHIP_ER0 = 8'h60;
  localparam logic [7:0] OP_CHIP_ER1 = 8'hc7;
  localparam logic [7:0] OP_PWR_DN = 8'hb9;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_HIPERF = 8'ha3;
  localparam logic [7:0] OP_WAKE_ID = 8'hab;
  // ------------------------------------------------------------------
  // Frame bit counts
  // ------------------------------------------------------------------
  localparam int OPC_BITS = 8;
  localparam int SRW_BITS = 16;
  localparam int ADDR_END_BITS = 32;
  localparam int PGM_BITS = 40;
  localparam int WAKE_OUT_BITS = 32;
  // ------------------------------------------------------------------
  // Protection modes and reset values
  // ------------------------------------------------------------------
  localparam logic [1:0] PM_SOFT = 2'h0;
  localparam logic [1:0] PM_HW = 2'h1;
  localparam logic [1:0] PM_LOCK = 2'h2;
  localparam logic [1:0] PM_OTP = 2'h3;
  typedef struct packed {
    logic [1:0] protect_mode;
    logic [4:0] block_protect_field;
    logic quad_enable_bit;
    logic [2:0] security_lock_bits;
    logic protect_complement;
    logic [1:0] drive_strength_field;
  } sfc_nv_t;
  localparam sfc_nv_t NV_RST = '{2'h0, 5'h00, 1'h0, 3'h0, 1'h0, 2'h1};
  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
  } sfc_req_t;
endpackage
